// *** wdt_pkg.sv ***
`default_nettype none

package wdt_pkg;

   // Control register location and width on the special function bus.
   localparam logic [7:0] CTRL_ADDR = 8'hc0;
   localparam int REG_W = 8;

   // Field positions inside the control register.
   localparam int PRE_HI = 7;
   localparam int PRE_LO = 4;
   localparam int RESP_BIT = 3;
   localparam int FLAG_BIT = 2;
   localparam int RUN_BIT = 1;
   localparam int UNLOCK_BIT = 0;

   // Reset values of the control fields.
   localparam logic [3:0] PRE_RESET = 4'h7;
   localparam logic RESP_RESET = 1'b0;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic RUN_RESET = 1'b1;
   localparam logic UNLOCK_RESET = 1'b0;

   // Special timeout encodings and the tap used for invalid codes.
   localparam logic [3:0] PRE_AUTO = 4'h8;
   localparam logic [3:0] PRE_DOWNLOAD = 4'h9;
   localparam logic [3:0] PRE_LONGEST = 4'h7;

   // Timing: 16-bit counter of crystal ticks, shortest tap is 2^9 ticks.
   localparam int CNT_W = 16;
   localparam int TAP_BASE = 9;
   localparam int CRYSTAL_HZ = 32768;

endpackage : wdt_pkg

`default_nettype wire

// *** wdt_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdt_sync (
   input wire logic clock,
   input wire logic resetn,
   input wire logic asyncIn,
   output var logic syncOut
);

   logic stage1_ff;
   logic stage2_ff;

   // Two flops; the first one is read only by the second to keep
   // metastability from reaching any logic.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end
      else
      begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;

endmodule : wdt_sync

`default_nettype wire

// *** wdt_watchdog_timer.sv ***
// Function
// - Runs after reset, two-second timeout, resets
// - Clearing enable bit 1 stops the watchdog
// - Counter advances on crystal clock ticks
// - Flash lock forces response 0, enable 1
// - Locked enable and response ignore software writes
// - Field 7:4 picks tap, 2^field times 2^9
// - Codes 0 to 7 double from 15.6 ms
// - Codes 8, 9 reset immediately, 9 download
// - Expiry resets when bit 3 clear, else interrupts
// - Expiry sets timeout flag at bit 2
// - Flag clears by zero write or pin reset
// - Writing enable one clears the counter
// - Reset values: 7, 0, 0, 1, 0
// - Bit 0 unlocks the next control write
// - Timeout field stays writable while locked
// - Interrupt is high priority, never globally gated
`timescale 1ns/1ps
`default_nettype none

module wdt_watchdog_timer #(
   parameter int TAP_BASE_P = wdt_pkg::TAP_BASE
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic crystalInPin,
   input wire logic flashDogLockBit,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [wdt_pkg::REG_W-1:0] sfrWrData,
   input wire logic [7:0] bitAddr,
   input wire logic bitWrEn,
   input wire logic bitWrValue,
   output var logic [wdt_pkg::REG_W-1:0] sfrRdData,
   output var logic sysResetReq,
   output var logic downloadReset,
   output var logic dogIrq
);
   import wdt_pkg::*;

   logic [3:0] preSel_ff;
   logic respSel_ff;
   logic flag_ff;
   logic run_ff;
   logic unlock_ff;
   logic [CNT_W-1:0] count_ff;
   logic crystalPrev_ff;
   logic sysReset_ff;
   logic download_ff;
   logic irq_ff;
   logic [REG_W-1:0] rdData_ff;
   logic [3:0] nxt_preSel;
   logic nxt_respSel;
   logic nxt_flag;
   logic nxt_run;
   logic nxt_unlock;
   logic [CNT_W-1:0] nxt_count;
   logic crystalSync;

   // Replaces one bit of a byte, used for set/clear bit instructions.
   function automatic logic [7:0] set_bit(input logic [7:0] cur,
                                          input logic [2:0] idx,
                                          input logic val);
      logic [7:0] res;
      res = cur;
      res[idx] = val;
      set_bit = res;
   endfunction : set_bit

   // Last count value before expiry for a tap, 2^(base+tap) ticks.
   function automatic logic [CNT_W-1:0] last_count(input logic [3:0] tap);
      logic [CNT_W:0] span;
      span = {{CNT_W{1'b0}}, 1'b1} << (TAP_BASE_P + int'(tap));
      last_count = span[CNT_W-1:0] - 1'b1;
   endfunction : last_count

   // The crystal pin is foreign to the core clock, so it is synchronised.
   wdt_sync crystalSyncer (
      .clock(clock),
      .resetn(resetn),
      .asyncIn(crystalInPin),
      .syncOut(crystalSync)
   );

   // Lock view and the register as software sees it.
   wire lockOn = ~flashDogLockBit;
   wire effRun = run_ff | lockOn;
   wire effResp = respSel_ff & ~lockOn;
   wire [REG_W-1:0] ctrlByte = {preSel_ff, effResp, flag_ff, effRun,
                                unlock_ff};

   // Write decode; bit writes hit bit addresses 0xc0 to 0xc7.
   wire byteHit = sfrWrEn && (sfrAddr == CTRL_ADDR);
   wire bitHit = bitWrEn && (bitAddr[7:3] == CTRL_ADDR[7:3]);
   wire regWrite = byteHit || bitHit;
   wire otherWrite = (sfrWrEn && !byteHit) || (bitWrEn && !bitHit);
   wire [REG_W-1:0] wrByte = byteHit ? sfrWrData :
                             set_bit(ctrlByte, bitAddr[2:0], bitWrValue);
   wire [3:0] wrPre = sfrWrData[PRE_HI:PRE_LO];
   wire armReq = regWrite && !unlock_ff && wrByte[UNLOCK_BIT];
   wire applyWrite = regWrite && unlock_ff;
   wire rearm = applyWrite && wrByte[RUN_BIT];

   // Timeout decode; invalid codes fall back to the longest tap so that a
   // stray value still leaves a watchdog running.
   wire crystalTick = crystalSync & ~crystalPrev_ff;
   wire isSpecial = (preSel_ff == PRE_AUTO) || (preSel_ff == PRE_DOWNLOAD);
   wire [3:0] tapSel = preSel_ff[3] ? PRE_LONGEST : preSel_ff;
   wire [CNT_W-1:0] lastCount = last_count(tapSel);
   wire immediate = effRun && isSpecial;
   wire expiry = effRun && !isSpecial && crystalTick &&
                 (count_ff >= lastCount);
   wire fire = expiry || immediate;
   wire resetFire = immediate || (expiry && !effResp);

   // Next state of the control fields; hardware set of the flag wins.
   always_comb
   begin
      nxt_preSel = preSel_ff;
      nxt_respSel = respSel_ff;
      nxt_run = run_ff;
      nxt_flag = flag_ff;
      nxt_unlock = unlock_ff;
      if (applyWrite)
      begin
         nxt_preSel = wrByte[PRE_HI:PRE_LO];
         if (!lockOn)
         begin
            nxt_respSel = wrByte[RESP_BIT];
            nxt_run = wrByte[RUN_BIT];
         end
         if (!wrByte[FLAG_BIT])
         begin
            nxt_flag = 1'b0;
         end
         nxt_unlock = 1'b0;
      end
      else if (armReq)
      begin
         nxt_unlock = 1'b1;
      end
      else if (regWrite || otherWrite)
      begin
         nxt_unlock = 1'b0;
      end
      if (fire)
      begin
         nxt_flag = 1'b1;
      end
      // A watchdog reset restores defaults but keeps the flag.
      if (resetFire)
      begin
         nxt_preSel = PRE_RESET;
         nxt_respSel = RESP_RESET;
         nxt_run = RUN_RESET;
         nxt_unlock = UNLOCK_RESET;
      end
   end

   // Counter: held at zero while stopped, restarted on re-arm or expiry.
   always_comb
   begin
      nxt_count = count_ff;
      if (!effRun || rearm || fire)
      begin
         nxt_count = '0;
      end
      else if (crystalTick)
      begin
         nxt_count = count_ff + 1'b1;
      end
   end

   // Control register state; defaults give a 2 s reset watchdog.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         preSel_ff <= PRE_RESET;
         respSel_ff <= RESP_RESET;
         flag_ff <= FLAG_RESET;
         run_ff <= RUN_RESET;
         unlock_ff <= UNLOCK_RESET;
      end
      else
      begin
         preSel_ff <= nxt_preSel;
         respSel_ff <= nxt_respSel;
         flag_ff <= nxt_flag;
         run_ff <= nxt_run;
         unlock_ff <= nxt_unlock;
      end
   end

   // Counter and crystal edge history.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         count_ff <= '0;
         crystalPrev_ff <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         crystalPrev_ff <= crystalSync;
      end
   end

   // Registered outputs; the request is a level that the interrupt
   // controller takes at top priority with no global gate.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sysReset_ff <= 1'b0;
         download_ff <= 1'b0;
         irq_ff <= 1'b0;
         rdData_ff <= '0;
      end
      else
      begin
         sysReset_ff <= resetFire;
         download_ff <= immediate && (preSel_ff == PRE_DOWNLOAD);
         irq_ff <= nxt_flag & nxt_respSel & ~lockOn;
         rdData_ff <= (sfrAddr == CTRL_ADDR) ? ctrlByte : '0;
      end
   end

   assign sysResetReq = sysReset_ff;
   assign downloadReset = download_ff;
   assign dogIrq = irq_ff;
   assign sfrRdData = rdData_ff;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence armSeq;
      regWrite && !unlock_ff && wrByte[UNLOCK_BIT];
   endsequence
   sequence byteSeq;
      byteHit && !resetFire;
   endsequence

   disableQuiet_a: assert property ((!effRun && !regWrite) |=>
      !sysResetReq)
      else $error("Stopped watchdog issued a reset.");
   expiryReset_a: assert property ((expiry && !effResp) |=>
      (sysResetReq && flag_ff && preSel_ff == PRE_RESET))
      else $error("Expiry in reset mode did not reset.");
   irqRestart_a: assert property ((expiry && effResp) |=>
      (dogIrq && count_ff == '0 && !sysResetReq))
      else $error("Expiry in interrupt mode did not interrupt.");
   lockForce_a: assert property ((lockOn && expiry) |=>
      (sysResetReq && !dogIrq))
      else $error("Locked watchdog did not reset on expiry.");
   rearmClear_a: assert property ((rearm && !fire) |=>
      count_ff == '0)
      else $error("Enable write did not clear the counter.");
   downloadNow_a: assert property ((effRun && preSel_ff == PRE_DOWNLOAD)
      |=> (sysResetReq && downloadReset))
      else $error("Download code did not reset at once.");
   flagHold_a: assert property ((flag_ff && !applyWrite) |=>
      flag_ff)
      else $error("Timeout flag dropped without a zero write.");
   lockedWrite_a: assert property ((regWrite && !unlock_ff && !resetFire)
      |=> preSel_ff == $past(preSel_ff))
      else $error("Write without unlock changed the timeout.");
   unlockedPre_a: assert property (armSeq ##1 byteSeq |=>
      preSel_ff == $past(wrPre))
      else $error("Unlocked write did not load the timeout.");
   tickCount_a: assert property ((effRun && crystalTick && !fire &&
      !rearm) |=> count_ff == $past(count_ff) + 1'b1)
      else $error("Counter missed a crystal tick.");

endmodule : wdt_watchdog_timer

`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         errCount++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
      end \
   end

module tb;
   import wdt_pkg::*;
   // Short tap base keeps the longest timeout near two thousand cycles.
   localparam int TAP = 1;
   localparam int TICK = 8;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic flashDogLockBit = 1'b1;
   logic [7:0] sfrAddr = 8'hc0;
   logic sfrWrEn = 1'b0;
   logic [7:0] sfrWrData = 8'h00;
   logic [7:0] bitAddr = 8'h00;
   logic bitWrEn = 1'b0;
   logic bitWrValue = 1'b0;
   logic [7:0] sfrRdData;
   logic sysResetReq;
   logic downloadReset;
   logic dogIrq;
   logic [2:0] xCnt = 3'h0;
   wire logic crystalInPin;
   int errCount = 0;
   int checked = 0;
   int rstPulses = 0;
   logic [7:0] v;
   int n;
   logic [1:0] ev;

   wdt_watchdog_timer #(.TAP_BASE_P(TAP)) dut (.clock(clock),
      .resetn(resetn), .crystalInPin(crystalInPin),
      .flashDogLockBit(flashDogLockBit), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .bitAddr(bitAddr),
      .bitWrEn(bitWrEn), .bitWrValue(bitWrValue), .sfrRdData(sfrRdData),
      .sysResetReq(sysResetReq), .downloadReset(downloadReset),
      .dogIrq(dogIrq));

   // The crystal runs at one eighth of the core rate, taken from bit 2 of a counter on the core clock.
   initial
   begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock) xCnt <= xCnt + 3'h1;
   assign crystalInPin = xCnt[2];
   // Counting reset pulses lets a quiet window be judged afterwards.
   always @(posedge clock)
   begin
      if (sysResetReq === 1'b1)
      begin
         rstPulses <= rstPulses + 1;
      end
   end

   task summarize;
      $display("errors=%0d checks=%0d", errCount, checked);
      if (errCount == 0 && checked > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   task wrByte(input logic [7:0] d);
      @(posedge clock);
      sfrWrEn <= 1'b1;
      sfrAddr <= 8'hc0;
      sfrWrData <= d;
      @(posedge clock);
      sfrWrEn <= 1'b0;
   endtask : wrByte

   task wrBit(input logic [2:0] i, input logic b);
      @(posedge clock);
      bitWrEn <= 1'b1;
      bitAddr <= {5'h18, i};
      bitWrValue <= b;
      @(posedge clock);
      bitWrEn <= 1'b0;
   endtask : wrBit

   // The unlock bit comes straight before the modifying byte write, in the
   // very next cycle; callers keep the timeout code at nine or below.
   task unlockWr(input logic [7:0] d);
      wrBit(3'h0, 1'b1);
      sfrWrEn <= 1'b1;
      sfrAddr <= 8'hc0;
      sfrWrData <= d;
      @(posedge clock);
      sfrWrEn <= 1'b0;
   endtask : unlockWr

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfrAddr <= a;
      repeat (2) @(posedge clock);
      #1 d = sfrRdData;
   endtask : rd

   // Waits for a reset pulse or the interrupt, giving up after mx cycles.
   task waitEv(input int mx, output int cnt, output logic [1:0] e);
      cnt = 0;
      e = 2'b00;
      while (cnt < mx && e == 2'b00)
      begin
         @(posedge clock);
         #1 cnt++;
         if (sysResetReq === 1'b1 || dogIrq === 1'b1)
            e = {downloadReset | dogIrq, sysResetReq};
      end
      if (e == 2'b00)
      begin
         errCount++;
         $display("[FAIL] t=%0t got=0 exp=1 no event", $time);
         summarize();
      end
   endtask : waitEv

   task testDefault;
      rd(8'hc0, v);
      `CHK(v, 8'h72)
      waitEv(2400, n, ev);
      `CHK(ev, 2'b01)
      `CHK(n > 1900 && n < 2200, 1'b1)
      rd(8'hc0, v);
      `CHK(v, 8'h76)
      wrByte(8'h00);
      rd(8'hc0, v);
      `CHK(v, 8'h76)
      rd(8'h80, v);
      `CHK(v, 8'h00)
      $display("default timeout test done");
   endtask : testDefault

   // Each step of the field from code 0 to code 3 doubles the timeout.
   task testTaps;
      for (int c = 0; c < 4; c++)
      begin
         unlockWr({c[3:0], 4'h2});
         waitEv(400, n, ev);
         `CHK(ev, 2'b01)
         `CHK(n > ((2 << (TAP + c)) * TICK / 2) - 14, 1'b1)
         `CHK(n < ((2 << (TAP + c)) * TICK / 2) + 14, 1'b1)
      end
      $display("tap test done");
   endtask : testTaps

   task testIrqAndStop;
      int p;
      unlockWr(8'h0a);
      p = rstPulses;
      waitEv(100, n, ev);
      `CHK(ev, 2'b10)
      wrBit(3'h0, 1'b1);
      wrBit(3'h1, 1'b0);
      unlockWr(8'h00);
      repeat (200) @(posedge clock);
      #1 `CHK(dogIrq, 1'b0)
      `CHK(rstPulses, p)
      rd(8'hc0, v);
      `CHK(v, 8'h00)
      $display("interrupt and stop test done");
   endtask : testIrqAndStop

   task testSpecial;
      unlockWr(8'h82);
      waitEv(20, n, ev);
      `CHK(ev, 2'b01)
      unlockWr(8'h92);
      waitEv(20, n, ev);
      `CHK(ev, 2'b11)
      // Under the lock a request for an interrupt still ends in a reset.
      @(posedge clock);
      flashDogLockBit <= 1'b0;
      unlockWr(8'h0e);
      waitEv(100, n, ev);
      `CHK(ev, 2'b01)
      unlockWr(8'h5c);
      rd(8'hc0, v);
      `CHK(v, 8'h56)
      // Lifting the lock shows whether the blocked bits were stored.
      @(posedge clock);
      flashDogLockBit <= 1'b1;
      rd(8'hc0, v);
      `CHK(v, 8'h56)
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd(8'hc0, v);
      `CHK(v, 8'h72)
      $display("special code and lock test done");
   endtask : testSpecial

   initial
   begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      testDefault();
      testTaps();
      testIrqAndStop();
      testSpecial();
      summarize();
   end
endmodule : tb

`default_nettype wire
